// ===== hdl/hflcf_top.sv
// Purpose: builds outgoing and interprets incoming hf control frame headers
// Assumes: rx_hdr and stream inputs come from logic on mclk
// Notes:   every bus access takes one wait state
`timescale 1ns/1ps
// How it works
// - negotiation flag forces herald every series
// - otherwise herald only when parameters change
// - data acknowledge clears extended addressing flag
// - short addressing: bitmap field holds acknowledgements
// - extended addressing: bitmap field holds address bytes
// - source field holds low two bytes
// - destination field holds high two bytes
// - all-ones destination means broadcast
// - link state codes calling to dropping
// - timeout in 30 s units minus one
// - timeout computed before first transmission
// - retries repeat the same timeout
// - ack type zero is null acknowledge
// - ack type one activates bitmap
// - ack type two requests data ack
// - ack type three acknowledges herald
// - bytes per frame kept within 56..1023
// - zero frames count marks null herald
// - message size and next byte position
// - eight bit priority, zero lowest
// - receive next byte position field
// - user id, function bits, checksum trailer
// - checksum starts all ones over frame
// - frame type bit set for control
module hflcf_top
   import hflcf_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         reset,
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic              hreadyout,
   output logic [31:0]       hrdata,
   output logic              hresp,
   input  wire logic         rx_valid,
   input  wire hflcf_hdr_s   rx_hdr,
   input  wire logic [255:0] tx_ackmap,
   input  wire logic [255:0] tx_extaddr,
   input  wire logic         crc_clr,
   input  wire logic         crc_en,
   input  wire logic         crc_bit,
   output logic              tx_go,
   output hflcf_hdr_s        tx_hdr,
   output logic              herald_req
);

   // encode seconds as 30 s units minus one, saturating
   function automatic logic [3:0] tmo_code(input logic [15:0] s);
      logic [16:0] u;
      u = ({1'b0, s} + TMO_RND) / TMO_UNIT_S;
      if (u == 17'd0)
         tmo_code = 4'h0;
      else if (u > 17'd16)
         tmo_code = 4'hF;
      else
         tmo_code = 4'(u - 17'd1);
   endfunction

   // true when the word offset hits the given register
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] o);
      hit = (a == o);
   endfunction

   // bus state
   logic         pend_r,  pend_nxt;
   logic         wr_r,    wr_nxt;
   logic [7:0]   adr_r,   adr_nxt;
   logic         rdy_r,   rdy_nxt;
   logic [31:0]  rdat_r,  rdat_nxt;
   logic         wen;
   // software registers
   logic [9:0]   ctrl_r,  ctrl_nxt;
   logic [31:0]  addr_r,  addr_nxt;
   logic [15:0]  tmo_r,   tmo_nxt;
   logic [22:0]  her_r,   her_nxt;
   logic [23:0]  msz_r,   msz_nxt;
   logic [20:0]  mpos_r,  mpos_nxt;
   logic [23:0]  mid_r,   mid_nxt;
   logic [20:0]  rpos_r,  rpos_nxt;
   logic [13:0]  user_r,  user_nxt;
   logic [49:0]  func_r,  func_nxt;
   // receive status
   logic         hev_r,   hev_nxt;
   logic         bc_r,    bc_nxt;
   logic [1:0]   rack_r,  rack_nxt;
   logic [1:0]   rlst_r,  rlst_nxt;
   logic         seen_r,  seen_nxt;
   // transmit state
   logic [3:0]   code_r,  code_nxt;
   logic         go_r,    go_nxt;
   hflcf_hdr_s   hdr_r,   hdr_nxt;
   logic [22:0]  inf_r,   inf_nxt;
   logic         infv_r,  infv_nxt;
   logic         hreq_r,  hreq_nxt;
   logic [31:0]  crc_r,   crc_nxt;
   // decoded helpers
   logic         send_w;
   logic         retry_w;
   logic         nb_err;
   logic         null_her;
   logic [31:0]  status_w;

   // status word and herald checks
   always_comb begin
      nb_err   = her_r[9:0] < NBYTES_MIN;
      null_her = her_r[HER_NFR +: 8] == 8'd0;
      status_w = {18'd0, seen_r, null_her, nb_err, code_r,
                  rlst_r, rack_r, bc_r, hreq_r, hev_r};
   end

   // ahb-lite slave: capture address, answer after one wait state
   always_comb begin
      pend_nxt = 1'b0;
      wr_nxt   = wr_r;
      adr_nxt  = adr_r;
      rdy_nxt  = 1'b1;
      rdat_nxt = rdat_r;
      wen      = pend_r & wr_r;
      if (hsel && htrans[1] && hready) begin
         pend_nxt = 1'b1;
         wr_nxt   = hwrite;
         adr_nxt  = {haddr[7:2], 2'b00};
         rdy_nxt  = 1'b0;
      end
      if (pend_r && !wr_r) begin
         case (1'b1)
            hit(adr_r, OFS_CTRL):   rdat_nxt = {22'd0, ctrl_r};
            hit(adr_r, OFS_ADDR):   rdat_nxt = addr_r;
            hit(adr_r, OFS_TMO):    rdat_nxt = {16'd0, tmo_r};
            hit(adr_r, OFS_HERALD): rdat_nxt = {9'd0, her_r};
            hit(adr_r, OFS_MSGSZ):  rdat_nxt = {8'd0, msz_r};
            hit(adr_r, OFS_MSGPOS): rdat_nxt = {11'd0, mpos_r};
            hit(adr_r, OFS_MSGID):  rdat_nxt = {8'd0, mid_r};
            hit(adr_r, OFS_RXPOS):  rdat_nxt = {11'd0, rpos_r};
            hit(adr_r, OFS_USER):   rdat_nxt = {18'd0, user_r};
            hit(adr_r, OFS_FUNCLO): rdat_nxt = func_r[31:0];
            hit(adr_r, OFS_FUNCHI): rdat_nxt = {14'd0, func_r[49:32]};
            hit(adr_r, OFS_STATUS): rdat_nxt = status_w;
            hit(adr_r, OFS_CRC):    rdat_nxt = crc_r;
            default:                rdat_nxt = RST_WORD;
         endcase
      end
   end

   // bus flops; hreadyout idles high
   always_ff @(posedge mclk) begin
      if (reset) begin
         pend_r <= 1'b0;
         wr_r   <= 1'b0;
         adr_r  <= 8'h00;
         rdy_r  <= 1'b1;
         rdat_r <= RST_WORD;
      end else begin
         pend_r <= pend_nxt;
         wr_r   <= wr_nxt;
         adr_r  <= adr_nxt;
         rdy_r  <= rdy_nxt;
         rdat_r <= rdat_nxt;
      end
   end

   // register writes; send and retry bits act as one-shot commands
   always_comb begin
      ctrl_nxt = ctrl_r;
      addr_nxt = addr_r;
      tmo_nxt  = tmo_r;
      her_nxt  = her_r;
      msz_nxt  = msz_r;
      mpos_nxt = mpos_r;
      mid_nxt  = mid_r;
      rpos_nxt = rpos_r;
      user_nxt = user_r;
      func_nxt = func_r;
      send_w   = 1'b0;
      retry_w  = 1'b0;
      ctrl_nxt[CTRL_SEND]  = 1'b0;
      ctrl_nxt[CTRL_RETRY] = 1'b0;
      if (wen) begin
         case (1'b1)
            hit(adr_r, OFS_CTRL): begin
               ctrl_nxt = hwdata[9:0];
               send_w   = hwdata[CTRL_SEND];
               retry_w  = hwdata[CTRL_RETRY] & ~hwdata[CTRL_SEND];
            end
            hit(adr_r, OFS_ADDR):   addr_nxt = hwdata;
            hit(adr_r, OFS_TMO):    tmo_nxt  = hwdata[15:0];
            hit(adr_r, OFS_HERALD): her_nxt  = hwdata[22:0];
            hit(adr_r, OFS_MSGSZ):  msz_nxt  = hwdata[23:0];
            hit(adr_r, OFS_MSGPOS): mpos_nxt = hwdata[20:0];
            hit(adr_r, OFS_MSGID):  mid_nxt  = hwdata[23:0];
            hit(adr_r, OFS_RXPOS):  rpos_nxt = hwdata[20:0];
            hit(adr_r, OFS_USER):   user_nxt = hwdata[13:0];
            hit(adr_r, OFS_FUNCLO): func_nxt[31:0]  = hwdata;
            hit(adr_r, OFS_FUNCHI): func_nxt[49:32] = hwdata[17:0];
            default:                ctrl_nxt = ctrl_nxt;
         endcase
      end
   end

   // software register flops
   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl_r <= 10'd0;
         addr_r <= RST_WORD;
         tmo_r  <= 16'd0;
         her_r  <= {13'd0, RST_NBYTES};
         msz_r  <= 24'd0;
         mpos_r <= 21'd0;
         mid_r  <= 24'd0;
         rpos_r <= 21'd0;
         user_r <= 14'd0;
         func_r <= 50'd0;
      end else begin
         ctrl_r <= ctrl_nxt;
         addr_r <= addr_nxt;
         tmo_r  <= tmo_nxt;
         her_r  <= her_nxt;
         msz_r  <= msz_nxt;
         mpos_r <= mpos_nxt;
         mid_r  <= mid_nxt;
         rpos_r <= rpos_nxt;
         user_r <= user_nxt;
         func_r <= func_nxt;
      end
   end

   // receive interpretation of peer control frames
   always_comb begin
      hev_nxt  = hev_r;
      bc_nxt   = bc_r;
      rack_nxt = rack_r;
      rlst_nxt = rlst_r;
      seen_nxt = seen_r;
      if (wen && hit(adr_r, OFS_STATUS) && hwdata[STAT_SEEN])
         seen_nxt = 1'b0;
      if (rx_valid && rx_hdr.frame_type) begin
         hev_nxt  = rx_hdr.negot;
         bc_nxt   = rx_hdr.dst == ADDR_BCAST;
         rack_nxt = rx_hdr.ack;
         rlst_nxt = rx_hdr.lstate;
         seen_nxt = 1'b1;
      end
   end

   // receive status flops
   always_ff @(posedge mclk) begin
      if (reset) begin
         hev_r  <= 1'b0;
         bc_r   <= 1'b0;
         rack_r <= 2'd0;
         rlst_r <= 2'd0;
         seen_r <= 1'b0;
      end else begin
         hev_r  <= hev_nxt;
         bc_r   <= bc_nxt;
         rack_r <= rack_nxt;
         rlst_r <= rlst_nxt;
         seen_r <= seen_nxt;
      end
   end

   // transmit header build on send or retry
   always_comb begin
      hflcf_ack_e ak;
      logic       ext;
      logic [9:0] cw;
      // fields written with the send bit apply to this very build
      cw       = (wen && hit(adr_r, OFS_CTRL)) ? hwdata[9:0] : ctrl_r;
      ak       = hflcf_ack_e'(cw[CTRL_ACK +: 2]);
      ext      = cw[CTRL_EXT] & (ak != ACK_DATA);
      code_nxt = code_r;
      go_nxt   = send_w | retry_w;
      hdr_nxt  = hdr_r;
      inf_nxt  = inf_r;
      infv_nxt = infv_r;
      hreq_nxt = hev_r | ~infv_r | (inf_r != her_r);
      if (send_w)
         code_nxt = tmo_code(tmo_r);
      if (send_w || retry_w) begin
         hdr_nxt.frame_type = 1'b1;
         hdr_nxt.version    = 2'b00;
         hdr_nxt.cmode      = cw[CTRL_CMODE +: 2];
         hdr_nxt.negot      = cw[CTRL_NEG];
         hdr_nxt.ext_addr   = ext;
         hdr_nxt.src        = addr_r[15:0];
         hdr_nxt.dst        = addr_r[31:16];
         hdr_nxt.lstate     = hflcf_lst_e'(cw[CTRL_LST +: 2]);
         hdr_nxt.ltmo       = send_w ? code_nxt : code_r;
         hdr_nxt.ack        = ak;
         hdr_nxt.bmap       = ext ? tx_extaddr :
                              (ak == ACK_DATA) ? tx_ackmap :
                              256'd0;
         hdr_nxt.alt_ack    = 1'b0;
         hdr_nxt.rate_fmt   = her_r[HER_FMT];
         hdr_nxt.rate       = her_r[HER_RATE +: 3];
         hdr_nxt.ilv        = her_r[HER_ILV];
         hdr_nxt.nbytes     = nb_err ? NBYTES_MIN : her_r[9:0];
         hdr_nxt.nframes    = her_r[HER_NFR +: 8];
         hdr_nxt.msg_id     = mid_r[7:0];
         hdr_nxt.conn_id    = mid_r[15:8];
         hdr_nxt.msg_size   = msz_r;
         hdr_nxt.msg_pos    = mpos_r;
         hdr_nxt.rsv1       = 3'd0;
         hdr_nxt.prio       = mid_r[23:16];
         hdr_nxt.rx_pos     = rpos_r;
         hdr_nxt.rsv2       = 3'd0;
         hdr_nxt.user_id    = user_r;
         hdr_nxt.func       = func_r;
         if (!null_her) begin
            inf_nxt  = her_r;
            infv_nxt = 1'b1;
         end
      end
   end

   // transmit flops; herald demanded until parameters are in force
   always_ff @(posedge mclk) begin
      if (reset) begin
         code_r <= 4'h0;
         go_r   <= 1'b0;
         hdr_r  <= '0;
         inf_r  <= 23'd0;
         infv_r <= 1'b0;
         hreq_r <= 1'b1;
      end else begin
         code_r <= code_nxt;
         go_r   <= go_nxt;
         hdr_r  <= hdr_nxt;
         inf_r  <= inf_nxt;
         infv_r <= infv_nxt;
         hreq_r <= hreq_nxt;
      end
   end

   // serial frame checksum, msb first
   always_comb begin
      logic fb;
      fb      = crc_r[31] ^ crc_bit;
      crc_nxt = crc_r;
      if (crc_clr)
         crc_nxt = CRC_INIT;
      else if (crc_en)
         crc_nxt = {crc_r[30:0], 1'b0} ^ (fb ? CRC_POLY : RST_WORD);
   end

   // checksum flops start all ones
   always_ff @(posedge mclk) begin
      if (reset)
         crc_r <= CRC_INIT;
      else
         crc_r <= crc_nxt;
   end

   // outputs straight from flops except hresp, tied low
   assign hreadyout  = rdy_r;
   assign hrdata     = rdat_r;
   assign hresp      = 1'b0;
   assign tx_go      = go_r;
   assign tx_hdr     = hdr_r;
   assign herald_req = hreq_r;

endmodule

// ===== inc/hflcf_pkg.sv
// Purpose: shared constants and carriers for the hf link control framer
// Assumes: 32-bit ahb-lite register bus, one word per register
// Notes:   field widths follow the control frame layout
package hflcf_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_ADDR   = 8'h04;
   localparam logic [7:0] OFS_TMO    = 8'h08;
   localparam logic [7:0] OFS_HERALD = 8'h0C;
   localparam logic [7:0] OFS_MSGSZ  = 8'h10;
   localparam logic [7:0] OFS_MSGPOS = 8'h14;
   localparam logic [7:0] OFS_MSGID  = 8'h18;
   localparam logic [7:0] OFS_RXPOS  = 8'h1C;
   localparam logic [7:0] OFS_USER   = 8'h20;
   localparam logic [7:0] OFS_FUNCLO = 8'h24;
   localparam logic [7:0] OFS_FUNCHI = 8'h28;
   localparam logic [7:0] OFS_STATUS = 8'h2C;
   localparam logic [7:0] OFS_CRC    = 8'h30;
   // control and status register bits
   localparam int CTRL_SEND  = 0;
   localparam int CTRL_RETRY = 1;
   localparam int CTRL_NEG   = 2;
   localparam int CTRL_EXT   = 3;
   localparam int CTRL_CMODE = 4;
   localparam int CTRL_ACK   = 6;
   localparam int CTRL_LST   = 8;
   localparam int STAT_SEEN  = 13;
   // herald register field positions
   localparam int HER_NFR  = 10;
   localparam int HER_RATE = 18;
   localparam int HER_FMT  = 21;
   localparam int HER_ILV  = 22;
   // field limits and codes
   localparam logic [9:0]  NBYTES_MIN = 10'd56;
   localparam logic [16:0] TMO_UNIT_S = 17'd30;
   localparam logic [16:0] TMO_RND    = 17'd29;
   localparam logic [31:0] CRC_POLY   = 32'h04C1_1DB7;
   localparam logic [31:0] CRC_INIT   = 32'hFFFF_FFFF;
   localparam logic [15:0] ADDR_BCAST = 16'hFFFF;
   localparam logic [31:0] RST_WORD   = 32'h0000_0000;
   localparam logic [9:0]  RST_NBYTES = 10'd56;

   typedef enum logic [1:0] {
      LST_CALLING, LST_CALL_ACK, LST_LINKED, LST_DROPPING
   } hflcf_lst_e;
   typedef enum logic [1:0] {
      ACK_NULL, ACK_DATA, ACK_DATA_REQ, ACK_HERALD
   } hflcf_ack_e;

   // control frame header in transmission order
   typedef struct packed {
      logic         frame_type;
      logic [1:0]   version;
      logic [1:0]   cmode;
      logic         negot;
      logic         ext_addr;
      logic [15:0]  src;
      logic [15:0]  dst;
      hflcf_lst_e   lstate;
      logic [3:0]   ltmo;
      hflcf_ack_e   ack;
      logic [255:0] bmap;
      logic         alt_ack;
      logic         rate_fmt;
      logic [2:0]   rate;
      logic         ilv;
      logic [9:0]   nbytes;
      logic [7:0]   nframes;
      logic [7:0]   msg_id;
      logic [7:0]   conn_id;
      logic [23:0]  msg_size;
      logic [20:0]  msg_pos;
      logic [2:0]   rsv1;
      logic [7:0]   prio;
      logic [20:0]  rx_pos;
      logic [2:0]   rsv2;
      logic [13:0]  user_id;
      logic [49:0]  func;
   } hflcf_hdr_s;
endpackage

// ===== tb/hflcf_props.sv
// Purpose: port assertions for the control frame builder
// Assumes: one clock mclk, synchronous active high reset
// Notes:   attached to hflcf_top by bind
`timescale 1ns/1ps
module hflcf_props
   import hflcf_pkg::*;
(
   input wire logic         mclk,
   input wire logic         reset,
   input wire logic         hsel,
   input wire logic [1:0]   htrans,
   input wire logic         hready,
   input wire logic         hreadyout,
   input wire logic         rx_valid,
   input wire hflcf_hdr_s   rx_hdr,
   input wire logic [255:0] tx_ackmap,
   input wire logic [255:0] tx_extaddr,
   input wire logic         tx_go,
   input wire hflcf_hdr_s   tx_hdr,
   input wire logic         herald_req
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);

   // outgoing header content at each build pulse
   property p_ftype; tx_go |-> tx_hdr.frame_type; endproperty
   property p_ext; tx_go && tx_hdr.ack == ACK_DATA |-> !tx_hdr.ext_addr;
   endproperty
   property p_bext;
      tx_go && tx_hdr.ext_addr |-> tx_hdr.bmap == $past(tx_extaddr);
   endproperty
   property p_back;
      tx_go && tx_hdr.ack == ACK_DATA |-> tx_hdr.bmap == $past(tx_ackmap);
   endproperty
   property p_bnul;
      tx_go && !tx_hdr.ext_addr && tx_hdr.ack != ACK_DATA
         |-> tx_hdr.bmap == '0;
   endproperty
   property p_nby; tx_go |-> tx_hdr.nbytes >= NBYTES_MIN; endproperty
   // header only moves with a build pulse; a retry rebuilds it, keeping the last timeout code
   property p_hold; !tx_go |-> $stable(tx_hdr); endproperty
   // one wait state per accepted address phase
   property p_wait;
      hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout;
   endproperty
   // negotiation flag raises the herald demand two edges later
   property p_neg;
      rx_valid && rx_hdr.frame_type && rx_hdr.negot
         ##1 !(rx_valid && rx_hdr.frame_type) |=> herald_req;
   endproperty

   a_ftype: assert property (p_ftype) else $error("type bit");
   a_ext: assert property (p_ext) else $error("ext flag");
   a_bext: assert property (p_bext) else $error("ext bytes");
   a_back: assert property (p_back) else $error("ack map");
   a_bnul: assert property (p_bnul) else $error("map not zero");
   a_nby: assert property (p_nby) else $error("nbytes low");
   a_hold: assert property (p_hold) else $error("hdr moved");
   a_wait: assert property (p_wait) else $error("wait state");
   a_neg: assert property (p_neg) else $error("no herald");

   c_ext: cover property (tx_go && tx_hdr.ext_addr);
   c_ack: cover property (tx_go && tx_hdr.ack == ACK_DATA);
   c_neg: cover property (rx_valid && rx_hdr.negot);
endmodule

bind hflcf_top hflcf_props u_props (.mclk, .reset, .hsel, .htrans,
   .hready, .hreadyout, .rx_valid, .rx_hdr, .tx_ackmap, .tx_extaddr,
   .tx_go, .tx_hdr, .herald_req);

// ===== tb/hflcf_peer.sv
// Purpose: peer terminal handing parsed frames and frame bits
// Assumes: driven from the bench by task calls at rising edges
// Notes:   released lines show the inverse of their last value
`timescale 1ns/1ps
module hflcf_peer
   import hflcf_pkg::*;
(
   input wire logic mclk,
   output logic     rx_valid,
   output hflcf_hdr_s rx_hdr,
   output logic     crc_clr,
   output logic     crc_en,
   output logic     crc_bit
);
   // idle values at time zero
   initial begin
      rx_valid = 1'b0;
      rx_hdr = '0;
      crc_clr = 1'b0;
      crc_en = 1'b0;
      crc_bit = 1'b0;
   end

   // one parsed frame for a single cycle
   task automatic frame(input logic ft, input logic ng,
                        input logic [15:0] dst);
      hflcf_hdr_s f;
      f = '0;
      f.frame_type = ft;
      f.negot = ng;
      f.dst = dst;
      f.nbytes = NBYTES_MIN;
      f.nframes = 8'h01;
      rx_hdr <= f;
      rx_valid <= 1'b1;
      @(posedge mclk);
      rx_valid <= 1'b0;
      rx_hdr <= ~f;
   endtask

   // clear the checksum, then shift a word msb first
   task automatic bits(input logic [31:0] d);
      crc_clr <= 1'b1;
      @(posedge mclk);
      crc_clr <= 1'b0;
      crc_en <= 1'b1;
      for (int i = 31; i >= 0; i--) begin
         crc_bit <= d[i];
         @(posedge mclk);
      end
      crc_en <= 1'b0;
      crc_bit <= ~d[0];
   endtask
endmodule

// ===== tb/test_hf_link_control_frame_fields.sv
// Purpose: self-checking bench for the control frame builder
// Assumes: ahb-lite master tasks, peer model on the receive side
// Notes:   expected values are computed here from field rules
`timescale 1ns/1ps
module test_hf_link_control_frame_fields;
   import hflcf_pkg::*;
   logic mclk, reset, hsel, hwrite, hreadyout, hresp;
   logic tx_go, herald_req, rx_valid, crc_clr, crc_en, crc_bit;
   logic [31:0] haddr, hwdata, hrdata, v, cv;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [255:0] tx_ackmap, tx_extaddr;
   logic ext;
   hflcf_hdr_s rx_hdr, tx_hdr, h;
   int fail_count = 0;
   int n_checks = 0;
   int e;
   int s[7] = '{0, 25, 30, 31, 78, 450, 1000};

   hflcf_top dut (.mclk, .reset, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
      .rx_valid, .rx_hdr, .tx_ackmap, .tx_extaddr, .crc_clr, .crc_en,
      .crc_bit, .tx_go, .tx_hdr, .herald_req);
   hflcf_peer peer (.mclk, .rx_valid, .rx_hdr, .crc_clr, .crc_en,
      .crc_bit);

   // 10 MHz clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic chk(input logic [255:0] got, input logic [255:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // one single ahb transfer, waits on hready in both phases
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      v = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] x);
      bus(1'b0, a, 32'h0000_0000);
      chk(v, x);
      chk(hresp, 1'b0);
   endtask

   // command a build; the pulse stands as the write completes
   task automatic send(input logic [31:0] c);
      wr(OFS_CTRL, c);
      while (tx_go !== 1'b1) @(posedge mclk);
      h = tx_hdr;
   endtask

   task automatic settle(input logic x);
      repeat (3) @(posedge mclk);
      chk(herald_req, x);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      print_verdict();
   end

   // main sequence
   initial begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      tx_ackmap = {8{32'hA5C3_0F96}};
      tx_extaddr = {8{32'h1E2D_3C4B}};
      reset = 1'b1;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      chk(herald_req, 1'b1);
      rc(OFS_HERALD, {22'h00_0000, RST_NBYTES});
      rc(8'h3C, 32'h0000_0000);
      rc(OFS_CRC, CRC_INIT);
      $display("test reset done");

      for (int j = 0; j < 7; j++) begin
         wr(OFS_TMO, s[j]);
         send(32'h0000_0001);
         e = (s[j] + 29) / 30;
         e = (e > 0) ? e - 1 : 0;
         e = (e > 15) ? 15 : e;
         chk(h.ltmo, e);
      end
      wr(OFS_TMO, 32'h0000_0019);
      send(32'h0000_0002);
      chk(h.ltmo, 4'hF);
      $display("test timeout done");

      for (int i = 0; i < 8; i++) begin
         cv = {22'h00_0000, i[1:0], i[1:0], 2'b00, i[2], 3'b001};
         send(cv);
         ext = i[2] && (i[1:0] != 2'd1);
         chk(h.frame_type, 1'b1);
         chk(h.ack, i[1:0]);
         chk(h.lstate, i[1:0]);
         chk(h.ext_addr, ext);
         chk(h.bmap, ext ? tx_extaddr :
            (i[1:0] == 2'd1 ? tx_ackmap : 256'h0));
      end
      $display("test ack done");

      wr(OFS_ADDR, 32'hFFFF_1234);
      wr(OFS_HERALD, 32'h007F_FFFF);
      for (int a = 16; a <= 40; a += 4)
         wr(a[7:0], 32'hFFFF_FFFF);
      send(32'h0000_0001);
      chk(h.src, 16'h1234);
      chk(h.dst, ADDR_BCAST);
      chk({h.ilv, h.rate_fmt, h.rate, h.nframes, h.nbytes}, 23'h7F_FFFF);
      chk({h.msg_size, h.msg_pos}, 45'h1FFF_FFFF_FFFF);
      chk({h.rsv1, h.prio, h.rx_pos}, 32'h1FFF_FFFF);
      chk(h.user_id, 14'h3FFF);
      chk(h.func, 50'h3_FFFF_FFFF_FFFF);
      rc(OFS_MSGSZ, 32'h00FF_FFFF);
      settle(1'b0);
      wr(OFS_HERALD, 32'h0000_0014);
      send(32'h0000_0001);
      chk(h.nbytes, NBYTES_MIN);
      rc(OFS_STATUS, 32'h0000_1800 | {h.ltmo, 7'h02});
      settle(1'b1);
      wr(OFS_HERALD, 32'h007F_FFFF);
      settle(1'b0);
      $display("test fields done");

      peer.frame(1'b1, 1'b0, ADDR_BCAST);
      repeat (3) @(posedge mclk);
      bus(1'b0, OFS_STATUS, 32'h0000_0000);
      chk(v[2], 1'b1);
      peer.frame(1'b1, 1'b0, 16'h0001);
      repeat (3) @(posedge mclk);
      bus(1'b0, OFS_STATUS, 32'h0000_0000);
      chk(v[2], 1'b0);
      peer.frame(1'b1, 1'b1, 16'h0001);
      settle(1'b1);
      peer.frame(1'b0, 1'b0, 16'h0001);
      settle(1'b1);
      peer.frame(1'b1, 1'b0, 16'h0001);
      settle(1'b0);
      $display("test negotiation done");

      peer.bits(32'hC0DE_5A11);
      v = 32'hC0DE_5A11;
      cv = CRC_INIT;
      for (int i = 31; i >= 0; i--)
         cv = {cv[30:0], 1'b0} ^ ((cv[31] ^ v[i])
            ? CRC_POLY : 32'h0000_0000);
      rc(OFS_CRC, cv);
      $display("test checksum done");
      print_verdict();
   end
endmodule
